/* File: urto_top.sv */
// Serial receiver with programmable receive-timeout interrupt behind AXI4-Lite
//
// Overview of operation
// RULE1: While unread characters stay in the receive FIFO, the timeout fires again after a clear.
// RULE2: Software sets the timeout length through a high and a low count register.
// RULE3: Writing 1 to bit 6 of extended_feature_reg_two selects periodic timeout mode.
// RULE4: Reading interrupt_ident_reg clears a pending timeout interrupt.
// RULE5: Reads of rx_holding_reg, modem_status_reg and line_status_reg leave timeout state alone.
// RULE6: Writing 0 to bit 6 of extended_feature_reg_two returns to the default timeout mode.
// RULE7: In periodic mode every expiry of the counter raises the interrupt again.
// RULE8: In default mode each character restarts the counter; expiry with data pending fires. A character dropped on a full FIFO does not restart it.
`timescale 1ns/100ps
`include "urto_consts.svh"
module urto_top #(
  parameter logic [15:0] BAUD_DIV   = `URTO_BAUD_DIV_DEF,
  parameter int          FIFO_DEPTH = `URTO_FIFO_DEPTH
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_in,
  output logic             irq_timeout
);
  urto_pkg::urto_state_t st_reg;
  urto_pkg::urto_state_t st_next;

  logic        rx_s;
  logic        fifo_wr;
  logic        fifo_rd;
  logic [7:0]  fifo_rdata;
  logic        fifo_empty;
  logic        fifo_full;
  logic        iir_clr;
  logic        restart;
  logic        overrun_set;
  logic        tick;
  logic        armed;
  logic        expire;
  logic        periodic;
  logic [15:0] limit;

  urto_sync #(
    .RST_VAL (1'b1)
  ) u_rx_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (rx_in),
    .dout    (rx_s)
  );

  urto_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (fifo_wr),
    .wr_data (st_reg.rx_shift),
    .rd_en   (fifo_rd),
    .rd_data (fifo_rdata),
    .empty   (fifo_empty),
    .full    (fifo_full)
  );

  assign periodic = st_reg.extended_feature_reg_two[`URTO_EXTENDED_FEATURE_REG_TWO_PERIODIC_BIT];
  assign limit    = {st_reg.to_high, st_reg.to_low};
  assign tick     = (st_reg.tick_cnt == BAUD_DIV - 16'h0001);
  // Default mode only counts while data waits; periodic mode runs free
  assign armed    = periodic || !fifo_empty;
  // A zero count disables the timeout instead of firing every tick
  assign expire   = armed && tick && (limit != 16'h0000)
                    && (st_reg.to_cnt + 16'h0001 == limit); // [RULE7] [RULE8]

  always_comb begin
    st_next     = st_reg;
    fifo_wr     = 1'b0;
    fifo_rd     = 1'b0;
    iir_clr     = 1'b0;
    restart     = 1'b0;
    overrun_set = 1'b0;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_wdata[7:0];
      st_next.w_en   = s_axi_wstrb[0];
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = `URTO_RESP_OKAY;
      case (st_reg.aw_addr)
        `URTO_OFF_RX_HOLD, `URTO_OFF_INT_IDENT, `URTO_OFF_LINE_STATUS,
        `URTO_OFF_MODEM_STATUS: begin
        end
        `URTO_OFF_EXT_FEAT_TWO: begin
          if (st_reg.w_en) begin
            st_next.extended_feature_reg_two = st_reg.w_data; // [RULE3] [RULE6]
            restart      = 1'b1;
          end
        end
        `URTO_OFF_TO_LOW: begin
          if (st_reg.w_en) begin
            st_next.to_low = st_reg.w_data; // [RULE2]
            restart        = 1'b1;
          end
        end
        `URTO_OFF_TO_HIGH: begin
          if (st_reg.w_en) begin
            st_next.to_high = st_reg.w_data; // [RULE2]
            restart         = 1'b1;
          end
        end
        default: begin
          st_next.bresp = `URTO_RESP_SLVERR;
        end
      endcase
    end

    // Read channel: value captured at the address edge so the ident read
    // returns the state from before its own clear
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rd_busy = 1'b1;
      st_next.rd_addr = s_axi_araddr;
      st_next.rresp   = `URTO_RESP_OKAY;
      st_next.rdata   = 32'h00000000;
      case (s_axi_araddr)
        `URTO_OFF_RX_HOLD: begin
          fifo_rd = !fifo_empty; // [RULE5]
        end
        `URTO_OFF_INT_IDENT: begin
          st_next.rdata = st_reg.pending ? `URTO_IIR_TIMEOUT : `URTO_IIR_NONE;
          iir_clr       = 1'b1; // [RULE4]
        end
        `URTO_OFF_LINE_STATUS: begin
          st_next.rdata[`URTO_LSR_DATA_READY_BIT] = !fifo_empty;
          st_next.rdata[`URTO_LSR_OVERRUN_BIT]    = st_reg.overrun;
          st_next.overrun                         = 1'b0;
        end
        `URTO_OFF_MODEM_STATUS: begin
        end
        `URTO_OFF_EXT_FEAT_TWO: begin
          st_next.rdata[7:0] = st_reg.extended_feature_reg_two;
        end
        `URTO_OFF_TO_LOW: begin
          st_next.rdata[7:0] = st_reg.to_low;
        end
        `URTO_OFF_TO_HIGH: begin
          st_next.rdata[7:0] = st_reg.to_high;
        end
        default: begin
          st_next.rresp = `URTO_RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.rd_busy) begin
      st_next.rd_busy = 1'b0;
      st_next.rvalid  = 1'b1;
      if (st_reg.rd_addr == `URTO_OFF_RX_HOLD) begin
        st_next.rdata = {24'h000000, fifo_rdata};
      end
    end

    // Receiver: mid-bit sampling, 8 data bits, one stop bit
    unique case (st_reg.rx_state)
      urto_pkg::URTO_RX_IDLE: begin
        if (!rx_s) begin
          st_next.rx_state = urto_pkg::URTO_RX_START;
          st_next.rx_cnt   = 16'h0000;
        end
      end
      urto_pkg::URTO_RX_START: begin
        if (st_reg.rx_cnt == (BAUD_DIV >> 1)) begin
          st_next.rx_cnt   = 16'h0000;
          st_next.rx_bit   = 3'h0;
          st_next.rx_state = rx_s ? urto_pkg::URTO_RX_IDLE : urto_pkg::URTO_RX_DATA;
        end else begin
          st_next.rx_cnt = st_reg.rx_cnt + 16'h0001;
        end
      end
      urto_pkg::URTO_RX_DATA: begin
        if (st_reg.rx_cnt == BAUD_DIV - 16'h0001) begin
          st_next.rx_cnt   = 16'h0000;
          st_next.rx_shift = {rx_s, st_reg.rx_shift[7:1]};
          st_next.rx_bit   = st_reg.rx_bit + 3'h1;
          if (st_reg.rx_bit == 3'h7) begin
            st_next.rx_state = urto_pkg::URTO_RX_STOP;
          end
        end else begin
          st_next.rx_cnt = st_reg.rx_cnt + 16'h0001;
        end
      end
      urto_pkg::URTO_RX_STOP: begin
        if (st_reg.rx_cnt == BAUD_DIV - 16'h0001) begin
          st_next.rx_state = urto_pkg::URTO_RX_IDLE;
          // A bad stop bit drops the character silently
          if (rx_s) begin
            overrun_set = fifo_full;
            fifo_wr     = !fifo_full;
            restart     = !fifo_full && !periodic; // [RULE8]
          end
        end else begin
          st_next.rx_cnt = st_reg.rx_cnt + 16'h0001;
        end
      end
    endcase

    // Timeout counter in bit times
    st_next.tick_cnt = tick ? 16'h0000 : st_reg.tick_cnt + 16'h0001;
    if (restart || iir_clr || expire || !armed) begin
      st_next.to_cnt = 16'h0000; // [RULE1] [RULE7]
    end else if (tick) begin
      st_next.to_cnt = st_reg.to_cnt + 16'h0001;
    end
    // Only the ident read and expiry touch the flag; set wins the tie
    st_next.pending = (st_reg.pending && !iir_clr) || expire; // [RULE1] [RULE4] [RULE5]
    st_next.overrun = st_next.overrun || overrun_set;

    st_next.awready = !st_next.aw_full;
    st_next.wready  = !st_next.w_full;
    st_next.arready = !st_next.rd_busy && !st_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg          <= '0;
      st_reg.rx_state <= urto_pkg::URTO_RX_IDLE;
      st_reg.extended_feature_reg_two     <= `URTO_EXTENDED_FEATURE_REG_TWO_RST;
      st_reg.to_low   <= `URTO_TO_LOW_RST;
      st_reg.to_high  <= `URTO_TO_HIGH_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready  = st_reg.wready;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign irq_timeout   = st_reg.pending;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic ar_take;
  logic wr_exec;
  assign ar_take = s_axi_arvalid && st_reg.arready;
  assign wr_exec = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid && st_reg.w_en;

  a_retrig_after_clear: assert property ( // [RULE1]
    iir_clr && !periodic && !fifo_empty && !expire
    |=> (st_reg.to_cnt == 16'h0000) && !st_reg.pending)
    else $error("counter not restarted by clear with data pending");

  a_limit_low_write: assert property ( // [RULE2]
    wr_exec && st_reg.aw_addr == `URTO_OFF_TO_LOW
    |=> st_reg.to_low == $past(st_reg.w_data) && st_reg.to_cnt == 16'h0000)
    else $error("low timeout count not loaded");

  a_periodic_select: assert property ( // [RULE3]
    wr_exec && st_reg.aw_addr == `URTO_OFF_EXT_FEAT_TWO
    && st_reg.w_data[`URTO_EXTENDED_FEATURE_REG_TWO_PERIODIC_BIT]
    |=> periodic && s_axi_bvalid)
    else $error("periodic mode not entered");

  a_ident_clears: assert property ( // [RULE4]
    st_reg.pending && ar_take && s_axi_araddr == `URTO_OFF_INT_IDENT && !expire
    |=> !irq_timeout ##1 s_axi_rvalid && s_axi_rdata == `URTO_IIR_TIMEOUT)
    else $error("ident read did not clear or report timeout");

  a_status_read_keep: assert property ( // [RULE5]
    ar_take && (s_axi_araddr == `URTO_OFF_RX_HOLD || s_axi_araddr == `URTO_OFF_LINE_STATUS
    || s_axi_araddr == `URTO_OFF_MODEM_STATUS) && !expire
    |=> st_reg.pending == $past(st_reg.pending))
    else $error("status read disturbed timeout flag");

  a_default_return: assert property ( // [RULE6]
    wr_exec && st_reg.aw_addr == `URTO_OFF_EXT_FEAT_TWO
    && !st_reg.w_data[`URTO_EXTENDED_FEATURE_REG_TWO_PERIODIC_BIT]
    |=> !periodic)
    else $error("default mode not restored");

  a_periodic_fires: assert property ( // [RULE7]
    periodic && tick && limit != 16'h0000 && st_reg.to_cnt + 16'h0001 == limit
    && !restart |=> irq_timeout && st_reg.to_cnt == 16'h0000)
    else $error("periodic expiry did not raise interrupt");

  a_char_restarts: assert property ( // [RULE8]
    fifo_wr && !periodic |=> st_reg.to_cnt == 16'h0000 && !fifo_empty)
    else $error("received character did not restart counter");

  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before accepted");

  c_timeout_fire: cover property (!periodic && expire);
  c_periodic_fire: cover property (periodic && expire ##1 irq_timeout);
  c_ident_clear: cover property (st_reg.pending && iir_clr);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule

/* File: urto_consts.svh */
// Register offsets, field positions, reset values and counts of the receive-timeout block
`ifndef URTO_CONSTS_SVH
`define URTO_CONSTS_SVH

`define URTO_OFF_RX_HOLD      8'h00
`define URTO_OFF_INT_IDENT    8'h04
`define URTO_OFF_LINE_STATUS  8'h08
`define URTO_OFF_MODEM_STATUS 8'h0C
`define URTO_OFF_EXT_FEAT_TWO 8'h10
`define URTO_OFF_TO_LOW       8'h14
`define URTO_OFF_TO_HIGH      8'h18

`define URTO_EXTENDED_FEATURE_REG_TWO_PERIODIC_BIT 6
`define URTO_LSR_DATA_READY_BIT 0
`define URTO_LSR_OVERRUN_BIT    1

`define URTO_EXTENDED_FEATURE_REG_TWO_RST    8'h00
`define URTO_TO_LOW_RST  8'h28
`define URTO_TO_HIGH_RST 8'h00

`define URTO_IIR_TIMEOUT 32'h0000000C
`define URTO_IIR_NONE    32'h00000001

`define URTO_RESP_OKAY   2'h0
`define URTO_RESP_SLVERR 2'h2

`define URTO_BAUD_DIV_DEF 16'h087A
`define URTO_FIFO_DEPTH   16

`endif

/* File: urto_pkg.sv */
// Types of the receive-timeout block
package urto_pkg;

  typedef enum logic [3:0] {
    URTO_RX_IDLE  = 4'h1,
    URTO_RX_START = 4'h2,
    URTO_RX_DATA  = 4'h4,
    URTO_RX_STOP  = 4'h8
  } urto_rx_state_t;

  typedef struct packed {
    logic           aw_full;
    logic [7:0]     aw_addr;
    logic           w_full;
    logic [7:0]     w_data;
    logic           w_en;
    logic           awready;
    logic           wready;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           arready;
    logic           rd_busy;
    logic [7:0]     rd_addr;
    logic           rvalid;
    logic [1:0]     rresp;
    logic [31:0]    rdata;
    logic [7:0]     extended_feature_reg_two;
    logic [7:0]     to_low;
    logic [7:0]     to_high;
    logic           overrun;
    logic           pending;
    logic [15:0]    tick_cnt;
    logic [15:0]    to_cnt;
    urto_rx_state_t rx_state;
    logic [15:0]    rx_cnt;
    logic [2:0]     rx_bit;
    logic [7:0]     rx_shift;
  } urto_state_t;

endpackage

/* File: urto_sync.sv */
// Two-stage synchroniser for a pin input
`timescale 1ns/100ps
module urto_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic meta;
    logic stable;
  } urto_sync_t;

  urto_sync_t st_reg;
  urto_sync_t st_next;

  always_comb begin
    st_next = '{meta: din, stable: st_reg.meta};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '{meta: RST_VAL, stable: RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.stable;
endmodule

/* File: urto_fifo.sv */
// Receive FIFO with registered read data
`timescale 1ns/100ps
`include "urto_consts.svh"
module urto_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = `URTO_FIFO_DEPTH
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         rd_en,
  output logic [W-1:0]      rd_data,
  output logic              empty,
  output logic              full
);
  // Depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             count;
    logic [W-1:0]            rd_data;
  } urto_fifo_t;

  urto_fifo_t st_reg;
  urto_fifo_t st_next;
  logic       do_wr;
  logic       do_rd;

  always_comb begin
    st_next = st_reg;
    do_wr   = wr_en && (st_reg.count != (AW+1)'(DEPTH));
    do_rd   = rd_en && (st_reg.count != '0);
    if (do_wr) begin
      st_next.mem[st_reg.wr_ptr] = wr_data;
      st_next.wr_ptr             = st_reg.wr_ptr + AW'(1);
    end
    if (do_rd) begin
      st_next.rd_data = st_reg.mem[st_reg.rd_ptr];
      st_next.rd_ptr  = st_reg.rd_ptr + AW'(1);
    end
    if (do_wr && !do_rd) begin
      st_next.count = st_reg.count + (AW+1)'(1);
    end else if (do_rd && !do_wr) begin
      st_next.count = st_reg.count - (AW+1)'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd_data;
  assign empty   = (st_reg.count == '0);
  assign full    = (st_reg.count == (AW+1)'(DEPTH));
endmodule

/* File: urto_tx_model.sv */
// Remote serial transmitter driving the receive line, 8N1, LSB first
`timescale 1ns/100ps
module urto_tx_model #(
  parameter logic [15:0] BAUD_DIV = 16'h0008
) (
  input  wire logic aclk,
  output logic      rx_line
);
  // Mark level while no frame is under way
  initial rx_line = 1'b1;

  task automatic send_char(input logic [7:0] ch);
    logic [9:0] frame;
    frame = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      rx_line <= frame[i];
      repeat (BAUD_DIV - 1) @(posedge aclk);
    end
    // Let the stop bit end before the caller moves on
    repeat (4) @(posedge aclk);
  endtask
endmodule

/* File: test_urto_top.sv */
// Self-checking bench for the receive-timeout block
`timescale 1ns/100ps
`include "urto_consts.svh"
module test_urto_top;
  localparam logic [15:0] BDIV = 16'h0008;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        rx_line;
  logic        irq;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          err_total;
  int          n_tests;

  urto_top #(.BAUD_DIV(BDIV), .FIFO_DEPTH(16)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_in(rx_line), .irq_timeout(irq)
  );

  urto_tx_model #(.BAUD_DIV(BDIV)) tx (.aclk(aclk), .rx_line(rx_line));

  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Both channels offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rs);
    chk({30'h0, rs}, {30'h0, `URTO_RESP_OKAY}, "write response");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    axi_read(a, rd, rs);
    chk(rd, exp, msg);
    chk({30'h0, rs}, {30'h0, `URTO_RESP_OKAY}, "read response");
  endtask

  // Bounded wait; the figure covers limit ticks plus two ticks of phase
  task automatic wait_irq(input int max, input logic exp, input string msg);
    for (int i = 0; i < max; i++) begin
      @(posedge aclk);
      if (irq === 1'b1 && exp) break;
    end
    chk({31'h0, irq}, {31'h0, exp}, msg);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #80000;
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    araddr = 8'h00;
    err_total = 0;
    n_tests = 0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`URTO_OFF_EXT_FEAT_TWO, 32'h00000000, "feature reset");
    rd_chk(`URTO_OFF_TO_LOW, 32'h00000028, "low count reset");
    rd_chk(`URTO_OFF_TO_HIGH, 32'h00000000, "high count reset");
    axi_read(8'h1C, rd, rs);
    chk({30'h0, rs}, {30'h0, `URTO_RESP_SLVERR}, "unmapped read");
    axi_write(8'h1C, 32'h00000055, rs);
    chk({30'h0, rs}, {30'h0, `URTO_RESP_SLVERR}, "unmapped write");
    // Large value lands in the high half
    wr(`URTO_OFF_TO_HIGH, 32'h000000A5);
    rd_chk(`URTO_OFF_TO_HIGH, 32'h000000A5, "high count");
    wr(`URTO_OFF_TO_HIGH, 32'h00000000);
    wr(`URTO_OFF_TO_LOW, 32'h00000004);
    rd_chk(`URTO_OFF_TO_LOW, 32'h00000004, "low count");
    // Byte strobe low: accepted but nothing stored
    wstrb <= 4'h0;
    wr(`URTO_OFF_TO_LOW, 32'h00000077);
    wstrb <= 4'hF;
    rd_chk(`URTO_OFF_TO_LOW, 32'h00000004, "masked write ignored");
    wait_irq(200, 1'b0, "no timeout while empty");
    tx.send_char(8'h5A);
    chk({31'h0, irq}, 32'h0, "early timeout");
    wait_irq(6 * BDIV, 1'b1, "default timeout");
    rd_chk(`URTO_OFF_INT_IDENT, `URTO_IIR_TIMEOUT, "ident pending");
    chk({31'h0, irq}, 32'h0, "cleared by ident read");
    wait_irq(6 * BDIV, 1'b1, "refire with data left");
    // Pending must survive data, status and modem reads
    rd_chk(`URTO_OFF_LINE_STATUS, 32'h00000001, "data ready");
    rd_chk(`URTO_OFF_MODEM_STATUS, 32'h00000000, "modem status");
    rd_chk(`URTO_OFF_RX_HOLD, 32'h0000005A, "first char");
    chk({31'h0, irq}, 32'h1, "kept over reads");
    rd_chk(`URTO_OFF_INT_IDENT, `URTO_IIR_TIMEOUT, "ident clear");
    rd_chk(`URTO_OFF_INT_IDENT, `URTO_IIR_NONE, "ident none");
    // Chars ten ticks apart must not reach a twelve tick limit
    wr(`URTO_OFF_TO_LOW, 32'h0000000C);
    tx.send_char(8'hC3);
    tx.send_char(8'h3C);
    chk({31'h0, irq}, 32'h0, "restart per char");
    wait_irq(14 * BDIV, 1'b1, "timeout after burst");
    rd_chk(`URTO_OFF_RX_HOLD, 32'h000000C3, "second char");
    rd_chk(`URTO_OFF_RX_HOLD, 32'h0000003C, "third char");
    rd_chk(`URTO_OFF_INT_IDENT, `URTO_IIR_TIMEOUT, "clear after drain");
    for (int i = 0; i < 3; i++) begin
      rd_chk(`URTO_OFF_RX_HOLD, 32'h0000003C, "empty holds last");
      rd_chk(`URTO_OFF_LINE_STATUS, 32'h00000000, "empty status");
      rd_chk(`URTO_OFF_MODEM_STATUS, 32'h00000000, "modem again");
    end
    wait_irq(30 * BDIV, 1'b0, "no spurious timeout");
    // Periodic mode fires with an empty FIFO, again after each clear
    wr(`URTO_OFF_EXT_FEAT_TWO, 32'h00000040);
    rd_chk(`URTO_OFF_EXT_FEAT_TWO, 32'h00000040, "periodic set");
    wait_irq(14 * BDIV, 1'b1, "periodic expiry");
    rd_chk(`URTO_OFF_INT_IDENT, `URTO_IIR_TIMEOUT, "periodic clear");
    wait_irq(14 * BDIV, 1'b1, "next periodic expiry");
    wr(`URTO_OFF_EXT_FEAT_TWO, 32'h00000000);
    rd_chk(`URTO_OFF_INT_IDENT, `URTO_IIR_TIMEOUT, "clear before default");
    wait_irq(30 * BDIV, 1'b0, "default mode idle");
    // Seventeenth char finds the FIFO full and raises overrun
    for (int i = 0; i < 17; i++) begin
      tx.send_char(8'(i));
    end
    rd_chk(`URTO_OFF_LINE_STATUS, 32'h00000003, "overrun flagged");
    rd_chk(`URTO_OFF_LINE_STATUS, 32'h00000001, "overrun cleared by read");
    for (int i = 0; i < 16; i++) begin
      rd_chk(`URTO_OFF_RX_HOLD, 32'(i), "fifo order");
    end
    // Pending may or may not have fired during the drain; just clear it
    axi_read(`URTO_OFF_INT_IDENT, rd, rs);
    wait_irq(30 * BDIV, 1'b0, "idle after drain");
    print_verdict();
  end
endmodule
